// file: flash_led_brightness_flag_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Seven-bit flash current code, low bits
// - Scale-back enable bit drops current to torch at 125 degrees
// - Shutdown at 150 degrees, never disabled
// - Seven-bit torch current code, bit seven reserved
// - Flags byte carries eight fault and event bits
// - Writing identity bit seven resets the device
// - Identity reads device code and revision
// - Target address, then index, then data
// - Ack received bytes, none after sent bytes
module flash_led_brightness_flag_regs
  import flash_regs_pkg::*;
#(
  parameter logic [2:0] DEVICE_CODE = 3'h5, // Arbitrary value
  parameter logic [2:0] REVISION_CODE = 3'h6 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_n,
  input wire logic overvoltage_fault,
  input wire logic input_voltage_flash_monitor,
  input wire logic short_fault,
  input wire logic current_limit,
  input wire logic die_at_125c,
  input wire logic die_at_150c,
  input wire logic undervoltage_lockout,
  input wire logic flash_timeout,
  output logic [6:0] flash_code,
  output logic [6:0] torch_code,
  output logic thermal_current_scaleback_en,
  output logic drop_to_torch,
  output logic thermal_shutdown,
  output logic soft_reset_pulse
);

  logic [9:0] raw;
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic [1:0] bus_prev_q;
  logic scl_s, sda_s, scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] evt;
  bus_state_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shr_q, shr_d, tx_q, tx_d, idx_q, idx_d, flash_q, flash_d, flags_q, flags_d, rd_byte;
  logic [6:0] torch_q, torch_d;
  logic drv_n_q, drv_n_d, soft_q, soft_d, drop_q, drop_d, shut_q, shut_d, clr, wr;

  assign raw = {scl_in, sda_in, overvoltage_fault, input_voltage_flash_monitor, short_fault,
                current_limit, die_at_125c, die_at_150c, undervoltage_lockout, flash_timeout};
  assign scl_s = sync2_q[9];
  assign sda_s = sync2_q[8];
  assign scl_rise = scl_s & ~bus_prev_q[1];
  assign scl_fall = ~scl_s & bus_prev_q[1];
  // Start and stop only count while the clock line stays high
  assign start_seen = scl_s & bus_prev_q[1] & ~sda_s & bus_prev_q[0];
  assign stop_seen = scl_s & bus_prev_q[1] & sda_s & ~bus_prev_q[0];

  // Two-stage synchroniser for every pin and analog input; edges look at stage two only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 10'h300;
      sync2_q <= 10'h300;
      bus_prev_q <= 2'h3;
    end else if (clk_en) begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      bus_prev_q <= {scl_s, sda_s};
    end
  end

  // Event bits in flag order; scale-back flags only when it really acts
  always_comb begin
    evt = 8'h00;
    evt[FLAG_OVERVOLTAGE] = sync2_q[7];
    evt[FLAG_INPUT_MONITOR] = sync2_q[6];
    evt[FLAG_SHORT] = sync2_q[5];
    evt[FLAG_CURRENT_LIMIT] = sync2_q[4];
    evt[FLAG_SCALEBACK] = sync2_q[3] & flash_q[SCALEBACK_BIT];
    evt[FLAG_SHUTDOWN] = sync2_q[2];
    evt[FLAG_UNDERVOLTAGE] = sync2_q[1];
    evt[FLAG_TIMEOUT] = sync2_q[0];
  end

  // Read data; unmapped indices read as zero
  always_comb begin
    if (idx_q == IDX_FLASH) begin
      rd_byte = flash_q;
    end else if (idx_q == IDX_TORCH) begin
      rd_byte = {1'b0, torch_q};
    end else if (idx_q == IDX_FLAGS) begin
      rd_byte = flags_q;
    end else if (idx_q == IDX_IDENT) begin
      rd_byte = {2'b00, DEVICE_CODE, REVISION_CODE};
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Bus target, register writes, flags and thermal decisions
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    shr_d = shr_q;
    tx_d = tx_q;
    idx_d = idx_q;
    drv_n_d = drv_n_q;
    flash_d = flash_q;
    torch_d = torch_q;
    soft_d = 1'b0;
    clr = 1'b0;
    wr = 1'b0;
    if (soft_q) begin
      flash_d = FLASH_RST;
      torch_d = TORCH_RST;
    end
    if (start_seen) begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      drv_n_d = 1'b1;
    end else if (stop_seen) begin
      st_d = ST_IDLE;
      cnt_d = 4'h0;
      drv_n_d = 1'b1;
    end else if (st_q != ST_IDLE) begin
      if (scl_rise) begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q < BIT_ACK) begin
          shr_d = {shr_q[6:0], sda_s};
        end else if (st_q == ST_READ && sda_s) begin
          st_d = ST_IDLE; // Host declined more data
        end
      end else if (scl_fall) begin
        if (cnt_q == BIT_ACK) begin
          drv_n_d = 1'b0;
          case (st_q)
            ST_ADDR: begin
              if (shr_q[7:1] == TARGET_ADDR) begin
                st_d = shr_q[0] ? ST_READ : ST_INDEX;
              end else begin
                st_d = ST_IDLE;
                drv_n_d = 1'b1;
              end
            end
            ST_INDEX: begin
              idx_d = shr_q;
              st_d = ST_WDATA;
            end
            ST_WDATA: begin
              wr = 1'b1;
              idx_d = idx_q + 8'h01;
            end
            default: begin
              drv_n_d = 1'b1;
            end
          endcase
        end else if (cnt_q == BIT_END) begin
          cnt_d = 4'h0;
          drv_n_d = 1'b1;
          if (st_q == ST_READ) begin
            tx_d = rd_byte;
            drv_n_d = rd_byte[7];
            clr = (idx_q == IDX_FLAGS);
            idx_d = idx_q + 8'h01;
          end
        end else if (st_q == ST_READ && cnt_q != 4'h0) begin
          tx_d = {tx_q[6:0], 1'b0};
          drv_n_d = tx_q[6]; // Most significant bit first
        end
      end
    end
    if (wr) begin
      if (idx_q == IDX_FLASH) begin
        flash_d = shr_q;
      end else if (idx_q == IDX_TORCH) begin
        torch_d = shr_q[6:0];
      end else if (idx_q == IDX_IDENT) begin
        soft_d = shr_q[SOFT_RESET_BIT];
      end
    end
    // New events win over a read clear or a soft reset in the same cycle
    flags_d = ((soft_q | clr) ? FLAGS_RST : flags_q) | evt;
    drop_d = flash_q[SCALEBACK_BIT] & sync2_q[3];
    shut_d = sync2_q[2];
  end

  // State registers; clock enable low freezes all of it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shr_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 8'h00;
      drv_n_q <= 1'b1;
      flash_q <= FLASH_RST;
      torch_q <= TORCH_RST;
      flags_q <= FLAGS_RST;
      soft_q <= 1'b0;
      drop_q <= 1'b0;
      shut_q <= 1'b0;
      sda_out <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      shr_q <= shr_d;
      tx_q <= tx_d;
      idx_q <= idx_d;
      drv_n_q <= drv_n_d;
      flash_q <= flash_d;
      torch_q <= torch_d;
      flags_q <= flags_d;
      soft_q <= soft_d;
      drop_q <= drop_d;
      shut_q <= shut_d;
      sda_out <= 1'b0; // Open drain only ever pulls low
    end
  end

  assign sda_drive_n = drv_n_q;
  assign flash_code = flash_q[6:0];
  assign torch_code = torch_q;
  assign thermal_current_scaleback_en = flash_q[SCALEBACK_BIT];
  assign drop_to_torch = drop_q;
  assign thermal_shutdown = shut_q;
  assign soft_reset_pulse = soft_q;

  // Checks; frozen cycles are excluded by sampling only when enabled, except in the torch and identity read checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_flash_write: assert property (clk_en && wr && idx_q == IDX_FLASH && !soft_q |=>
    flash_code == $past(shr_q[6:0])) else $error("flash code not taken from write");
  a_scaleback_drop: assert property (clk_en && flash_q[SCALEBACK_BIT] && sync2_q[3] && !soft_q ##1 clk_en
    |-> drop_to_torch) else $error("scale-back did not drop current");
  a_scaleback_off: assert property (clk_en && !flash_q[SCALEBACK_BIT] |=> !drop_to_torch)
    else $error("drop without scale-back enabled");
  a_shutdown_always: assert property (clk_en && sync2_q[2] |=> thermal_shutdown)
    else $error("thermal shutdown missed");
  a_torch_reserved: assert property (idx_q == IDX_TORCH |-> rd_byte[7] == 1'b0)
    else $error("reserved torch bit read as one");
  a_flag_latch: assert property (clk_en && sync2_q[7] |=> flags_q[FLAG_OVERVOLTAGE])
    else $error("overvoltage flag not latched");
  a_flag_clear: assert property (clk_en && clr && evt == 8'h00 |=> flags_q == 8'h00)
    else $error("flags not cleared by read");
  a_soft_reset: assert property (clk_en && soft_q ##1 clk_en |-> flash_q == FLASH_RST && torch_q == TORCH_RST)
    else $error("soft reset did not restore defaults");
  a_ident_read: assert property (idx_q == IDX_IDENT |-> rd_byte == {2'b00, DEVICE_CODE, REVISION_CODE})
    else $error("identity byte wrong");
  a_addr_ack: assert property (clk_en && scl_fall && !start_seen && !stop_seen && st_q == ST_ADDR
    && cnt_q == BIT_ACK && shr_q[7:1] == TARGET_ADDR |=> !sda_drive_n) else $error("address not acked");
  a_read_no_ack: assert property (clk_en && scl_fall && !start_seen && !stop_seen && st_q == ST_READ
    && cnt_q == BIT_ACK |=> sda_drive_n) else $error("ack driven after sent byte");

  c_write: cover property (wr && idx_q == IDX_FLASH);
  c_read_flags: cover property (clr);
  c_soft_reset: cover property (soft_q);
  c_host_nack: cover property (st_q == ST_READ ##1 st_q == ST_IDLE);

endmodule
`default_nettype wire

// file: flash_regs_pkg.sv
package flash_regs_pkg;
  // Bus address and register indices
  localparam logic [6:0] TARGET_ADDR = 7'h64;
  localparam logic [7:0] IDX_FLASH = 8'h03;
  localparam logic [7:0] IDX_TORCH = 8'h04;
  localparam logic [7:0] IDX_FLAGS = 8'h05;
  localparam logic [7:0] IDX_IDENT = 8'h06;
  // Values after power-on or software reset
  localparam logic [7:0] FLASH_RST = 8'h80;
  localparam logic [6:0] TORCH_RST = 7'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // Field positions
  localparam int SCALEBACK_BIT = 7;
  localparam int SOFT_RESET_BIT = 7;
  localparam int FLAG_OVERVOLTAGE = 7;
  localparam int FLAG_INPUT_MONITOR = 6;
  localparam int FLAG_SHORT = 5;
  localparam int FLAG_CURRENT_LIMIT = 4;
  localparam int FLAG_SCALEBACK = 3;
  localparam int FLAG_SHUTDOWN = 2;
  localparam int FLAG_UNDERVOLTAGE = 1;
  localparam int FLAG_TIMEOUT = 0;
  // Bit counter marks within one byte slot
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  // Bus target states, Gray coded along the write path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_INDEX = 3'h3,
    ST_WDATA = 3'h2,
    ST_READ = 3'h6
  } bus_state_type;
endpackage

// file: i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // Slow phases stay well clear of the target's synchroniser delay
  task automatic half();
    repeat (10) @(negedge ref_clk);
  endtask
  // Also a repeated start; data rises while the clock is low, then falls while the clock is high
  task automatic start();
    half();
    sda = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    half();
    sda = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda = 1'b1;
    half();
  endtask
  // Data held past the clock fall, so the target never sees it move early
  task automatic bit_io(input logic b, output logic r);
    repeat (5) @(negedge ref_clk);
    sda = b;
    half();
    scl = 1'b1;
    half();
    r = sda_line;
    scl = 1'b0;
  endtask
  // Byte out, most significant bit first, then the ack slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in; the host always answers with a nack
  task automatic recv(output logic [7:0] d, output logic rel);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    rel = r;
  endtask
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
endmodule
`default_nettype wire

// file: test_flash_led_brightness_flag_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_led_brightness_flag_regs;
  import flash_regs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] faults = 8'h00;
  logic scl, host_sda, sda_out, sda_drive_n, sb_en, drop, shut, srst;
  logic [6:0] flash_code, torch_code;
  logic [7:0] d;
  int miscompares = 0;
  int samples_checked = 0;
  int pulses = 0;
  wire sda_line = sda_drive_n ? host_sda : sda_out;
  // Clock and soft reset pulse counter; counted on the falling edge, away from the launching rising edge, so no race
  always #5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (srst === 1'b1) pulses++;
  i2c_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda(host_sda));
  flash_led_brightness_flag_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_drive_n(sda_drive_n), .overvoltage_fault(faults[7]),
    .input_voltage_flash_monitor(faults[6]), .short_fault(faults[5]), .current_limit(faults[4]),
    .die_at_125c(faults[3]), .die_at_150c(faults[2]), .undervoltage_lockout(faults[1]),
    .flash_timeout(faults[0]), .flash_code(flash_code), .torch_code(torch_code),
    .thermal_current_scaleback_en(sb_en), .drop_to_torch(drop), .thermal_shutdown(shut),
    .soft_reset_pulse(srst));
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic a0, a1, a2;
    host.start();
    host.send({TARGET_ADDR, 1'b0}, a0);
    host.send(idx, a1);
    host.send(v, a2);
    host.stop();
    check("write acks", 8'h07, {5'h00, a0, a1, a2});
  endtask
  // Index set by a write, then a repeated start for the read
  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    logic a0, a1, a2, a3;
    host.start();
    host.send({TARGET_ADDR, 1'b0}, a0);
    host.send(idx, a1);
    host.start();
    host.send({TARGET_ADDR, 1'b1}, a2);
    host.recv(v, a3);
    host.stop();
    check("read acks", 8'h0F, {4'h0, a0, a1, a2, a3});
  endtask
  // Clock enable low: an event that comes and goes while frozen is never seen
  task automatic t_freeze();
    clk_en = 1'b0;
    faults = 8'h84;
    repeat (5) @(negedge ref_clk);
    check("frozen shutdown", 8'h00, {7'h00, shut});
    faults = 8'h00;
    clk_en = 1'b1;
    repeat (5) @(negedge ref_clk);
    rd(IDX_FLAGS, d);
    check("frozen flags", 8'h00, d);
  endtask
  task automatic t_reset();
    check("flash_code", 8'h00, {1'b0, flash_code});
    check("scaleback_en", 8'h01, {7'h00, sb_en});
    rd(IDX_FLASH, d);
    check("flash reg", FLASH_RST, d);
    rd(IDX_TORCH, d);
    check("torch reg", 8'h00, d);
    rd(IDX_IDENT, d);
    check("ident reg", 8'h2E, d);
  endtask
  task automatic t_levels();
    wr(IDX_TORCH, 8'h95);
    check("torch_code", 8'h15, {1'b0, torch_code});
    wr(IDX_FLASH, 8'h85);
    check("flash_code", 8'h05, {1'b0, flash_code});
    check("scaleback_en", 8'h01, {7'h00, sb_en});
    rd(IDX_FLASH, d);
    check("flash reg", 8'h85, d);
  endtask
  task automatic t_wrong_addr();
    logic a;
    host.start();
    host.send(8'hCA, a);
    host.stop();
    check("foreign ack", 8'h00, {7'h00, a});
  endtask
  // Each event alone: latched, reported in its own bit, gone after one read
  task automatic t_flags();
    for (int i = 0; i < 8; i++) begin
      faults = 8'h01 << i;
      repeat (5) @(negedge ref_clk);
      check("drop_to_torch", {7'h00, i == 3}, {7'h00, drop});
      check("thermal_shutdown", {7'h00, i == 2}, {7'h00, shut});
      faults = 8'h00;
      rd(IDX_FLAGS, d);
      check("flags", 8'h01 << i, d);
      rd(IDX_FLAGS, d);
      check("flags again", 8'h00, d);
    end
  endtask
  task automatic t_shutdown();
    wr(IDX_FLASH, 8'h7F);
    check("flash_code", 8'h7F, {1'b0, flash_code});
    faults = 8'h0C;
    repeat (5) @(negedge ref_clk);
    check("drop off", 8'h00, {7'h00, drop});
    check("shutdown on", 8'h01, {7'h00, shut});
    faults = 8'h00;
    rd(IDX_FLAGS, d);
    check("flags", 8'h04, d);
  endtask
  task automatic t_soft_reset();
    wr(IDX_IDENT, 8'h80);
    check("reset pulses", 8'h01, pulses[7:0]);
    check("flash after", 8'h80, {sb_en, flash_code});
    check("torch after", 8'h00, {1'b0, torch_code});
    rd(IDX_IDENT, d);
    check("ident reg", 8'h2E, d);
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_levels();
    t_wrong_addr();
    t_flags();
    t_freeze();
    t_shutdown();
    t_soft_reset();
    report_and_stop();
  end
  // Watchdog well beyond the expected run of about 27k cycles
  initial begin
    #800us;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
